// ===== hw/serial_parameter_code_map.sv
// Serial parameter code bank of a drive controller
//
// Overview of operation
// - Node address accepts only 1 through 99
// - Multiples of ten are broadcast group addresses
// - Fault code reads 0/1, written 0 clears
// - Fault clear only acts once source is gone
// - Fault and state codes hidden from display
// - Operating-state word packs trip, limits, errors
// - Operating-state byte packs enable, control, alarms
// - Baud selector 0..3 gives 9600..1200, default 0
// - Eight trip entries, oldest discarded on push
// - First history code holds latest reset trip
// - Bank n maps codes from 250 times n
// - Automation enable: 0 off, 1 on
// - Ready needs no fitted module, low while a trip is latched
// - Loading defaults keeps automation enable unchanged
// - Up to 90 nodes, transmission faults detected
// - Trip acknowledge void while source active
`timescale 1ns/100ps
`default_nettype none

module serial_parameter_code_map (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // Telegram request from the serial link
    input wire logic I_CODE_WR,
    input wire logic I_CODE_RD,
    input wire logic [6:0] I_FRAME_ADDR,
    input wire logic I_FRAME_ERR,
    input wire logic [7:0] I_CODE_NUM,
    input wire logic [15:0] I_CODE_WDATA,
    // Telegram answer
    output logic O_CODE_ACK,
    output logic O_CODE_NAK,
    output logic [15:0] O_CODE_RDATA,
    // Local parameter display
    input wire logic [10:0] I_DISP_CODE,
    output logic O_DISP_VALID,
    output logic [15:0] O_DISP_DATA,
    // Drive state inputs
    input wire logic I_TRIP_SRC,
    input wire logic [7:0] I_TRIP_CODE,
    input wire logic I_CUR_LIMIT,
    input wire logic I_QUICK_STOP,
    input wire logic I_RUN,
    input wire logic I_ZERO_SPEED,
    input wire logic I_CTRL_ENABLE,
    input wire logic I_CTRL_RESET,
    input wire logic I_TERMINAL_CTRL,
    input wire logic I_SERIAL_CTRL,
    input wire logic [3:0] I_OP_ERR_NUM,
    // Settings and drive control outputs
    output logic [6:0] O_NODE_ADDR,
    output logic [1:0] O_BAUD_SEL,
    output logic [16:0] O_BIT_CYCLES,
    output logic [2:0] O_OP_MODE,
    output logic O_AUTOMATION_EN,
    output logic O_PULSE_INHIBIT,
    output logic O_READY
);

    // ********************************************************
    // Settings and state registers
    // ********************************************************
    logic [6:0] node_reg;  // Own node address
    logic [1:0] baud_reg;  // Baud selector
    logic [2:0] bank_reg;  // Code bank selector
    logic [2:0] mode_reg;  // Operating mode
    logic aif_reg;  // Automation interface enable
    logic trip_reg;  // Latched trip
    logic [7:0] trip_code_reg;  // Code of the latched trip
    logic [3:0] comm_err_reg;  // Last communication error number
    logic parameter_change_flag_reg;  // Parameter changed since last byte read
    logic ack_reg;  // Answer accepted
    logic nak_reg;  // Answer rejected
    logic [15:0] rdata_reg;  // Answer data
    logic disp_valid_reg;  // Display value allowed
    logic [15:0] disp_data_reg;  // Display value
    logic [63:0] hist_entries;  // Trip history, newest first

    // ********************************************************
    // Value check, used for every range-limited code
    // ********************************************************
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ********************************************************
    // Group address test: ten to ninety in steps of ten
    // ********************************************************
    function automatic logic is_group(input logic [6:0] a);
        is_group = (a != 7'h00) && (a <= 7'h5a) && ((a % 7'h0a) == 7'h00);
    endfunction

    // ********************************************************
    // Status word and byte assembly
    // ********************************************************
    logic [15:0] state_word;
    logic [7:0] state_byte;
    logic pulse_inhibit;

    // Pulses stay inhibited until the trip is acknowledged
    assign pulse_inhibit = trip_reg | ~I_CTRL_ENABLE;

    always_comb begin
        state_word = 16'h0000;
        state_word[drive_code_pkg::SW_TRIP] = trip_reg;
        state_word[drive_code_pkg::SW_CUR_LIMIT] = I_CUR_LIMIT;
        state_word[drive_code_pkg::SW_QUICK_STOP] = I_QUICK_STOP;
        state_word[drive_code_pkg::SW_PULSE_INHIBIT] = pulse_inhibit;
        state_word[drive_code_pkg::SW_RUN] = I_RUN;
        state_word[drive_code_pkg::SW_ZERO_SPEED] = I_ZERO_SPEED;
        state_word[drive_code_pkg::SW_CTRL_ENABLE] = I_CTRL_ENABLE;
        state_word[drive_code_pkg::SW_COMM_ERR_LSB +: 4] = comm_err_reg;
        state_word[drive_code_pkg::SW_OP_ERR_LSB +: 4] = I_OP_ERR_NUM;
    end

    always_comb begin
        state_byte = 8'h00;
        state_byte[drive_code_pkg::SB_CTRL_ENABLE] = I_CTRL_ENABLE;
        state_byte[drive_code_pkg::SB_CTRL_RESET] = I_CTRL_RESET;
        state_byte[drive_code_pkg::SB_TERMINAL] = I_TERMINAL_CTRL;
        state_byte[drive_code_pkg::SB_SERIAL] = I_SERIAL_CTRL;
        state_byte[drive_code_pkg::SB_PARAM_CHANGE] = parameter_change_flag_reg;
        state_byte[drive_code_pkg::SB_COMM_ALARM] = (comm_err_reg != 4'h0);
        state_byte[drive_code_pkg::SB_OP_ALARM] = (I_OP_ERR_NUM != 4'h0);
    end

    // ********************************************************
    // Code read decode, shared by link and display
    // ********************************************************
    function automatic logic [15:0] code_value(input logic [10:0] c);
        logic [2:0] idx;
        idx = 3'(c - drive_code_pkg::CODE_HIST_NEWEST);
        code_value = 16'h0000;
        if (c >= drive_code_pkg::CODE_HIST_NEWEST && c <= drive_code_pkg::CODE_HIST_OLDEST) begin
            code_value = {8'h00, hist_entries[idx*8 +: 8]};
        end else begin
            case (c)
                drive_code_pkg::CODE_OP_MODE: code_value = {13'h0000, mode_reg};
                drive_code_pkg::CODE_NODE_ADDRESS: code_value = {9'h000, node_reg};
                drive_code_pkg::CODE_FAULT_FLAG: code_value = {15'h0000, trip_reg};
                drive_code_pkg::CODE_STATE_WORD: code_value = state_word;
                drive_code_pkg::CODE_STATE_BYTE: code_value = {8'h00, state_byte};
                drive_code_pkg::CODE_BAUD_SELECT: code_value = {14'h0000, baud_reg};
                drive_code_pkg::CODE_BANK_SELECT: code_value = {13'h0000, bank_reg};
                drive_code_pkg::CODE_AUTOMATION_EN: code_value = {15'h0000, aif_reg};
                default: code_value = 16'h0000;
            endcase
        end
    endfunction

    // ********************************************************
    // Telegram addressing and bank mapping
    // ********************************************************
    logic addr_own;
    logic addr_group;
    logic req_any;
    logic req_ok;
    logic [10:0] bank_base;
    logic [10:0] eff_code;
    logic code_known;
    logic code_writable;

    // Own node or own broadcast group, only 90 node numbers remain
    assign addr_own = (I_FRAME_ADDR == node_reg);
    assign addr_group = is_group(I_FRAME_ADDR)
        && ((node_reg / 7'h0a) == (I_FRAME_ADDR / 7'h0a));
    assign req_any = (I_CODE_WR | I_CODE_RD) & (addr_own | addr_group);
    assign req_ok = req_any & ~I_FRAME_ERR;

    // Bank n shifts the reachable window by n times 250 codes
    assign bank_base = 11'(bank_reg * drive_code_pkg::BANK_STEP);
    assign eff_code = bank_base + {3'h0, I_CODE_NUM};

    assign code_writable = (eff_code == drive_code_pkg::CODE_OP_MODE)
        || (eff_code == drive_code_pkg::CODE_LOAD_DEFAULTS)
        || (eff_code == drive_code_pkg::CODE_NODE_ADDRESS)
        || (eff_code == drive_code_pkg::CODE_FAULT_FLAG)
        || (eff_code == drive_code_pkg::CODE_BAUD_SELECT)
        || (eff_code == drive_code_pkg::CODE_BANK_SELECT)
        || (eff_code == drive_code_pkg::CODE_AUTOMATION_EN);
    // Codes past the last bank end answer as unknown
    assign code_known = (eff_code <= drive_code_pkg::CODE_LAST)
        && (code_writable
        || (eff_code == drive_code_pkg::CODE_STATE_WORD)
        || (eff_code == drive_code_pkg::CODE_STATE_BYTE)
        || (eff_code >= drive_code_pkg::CODE_HIST_NEWEST
        && eff_code <= drive_code_pkg::CODE_HIST_OLDEST));

    // ********************************************************
    // Write value checks
    // ********************************************************
    logic [15:0] wd;
    logic val_ok;
    logic wr_ok;
    logic wr_bad;
    logic is_wr;

    assign wd = I_CODE_WDATA;
    assign is_wr = req_ok & I_CODE_WR;

    // Each writable code has its own legal value set
    always_comb begin
        case (eff_code)
            drive_code_pkg::CODE_NODE_ADDRESS:
                val_ok = in_range(wd, drive_code_pkg::NODE_MIN, drive_code_pkg::NODE_MAX)
                    && !is_group(wd[6:0]);
            drive_code_pkg::CODE_FAULT_FLAG: val_ok = (wd == 16'h0000);
            drive_code_pkg::CODE_BAUD_SELECT:
                val_ok = in_range(wd, 16'h0000, drive_code_pkg::BAUD_MAX);
            drive_code_pkg::CODE_BANK_SELECT:
                val_ok = in_range(wd, 16'h0000, drive_code_pkg::BANK_MAX);
            drive_code_pkg::CODE_OP_MODE:
                val_ok = in_range(wd, 16'h0000, drive_code_pkg::MODE_MAX);
            drive_code_pkg::CODE_AUTOMATION_EN:
                val_ok = in_range(wd, 16'h0000, drive_code_pkg::ENABLE_MAX);
            drive_code_pkg::CODE_LOAD_DEFAULTS: val_ok = (wd == 16'h0001);
            default: val_ok = 1'b0;
        endcase
    end

    assign wr_ok = is_wr & code_writable & val_ok;
    assign wr_bad = is_wr & ~(code_writable & val_ok);

    // Strobes per written code
    logic wr_node;
    logic wr_baud;
    logic wr_bank;
    logic wr_mode;
    logic wr_aif;
    logic wr_defaults;
    logic wr_clear;
    logic clear_done;

    assign wr_node = wr_ok & (eff_code == drive_code_pkg::CODE_NODE_ADDRESS);
    assign wr_baud = wr_ok & (eff_code == drive_code_pkg::CODE_BAUD_SELECT);
    assign wr_bank = wr_ok & (eff_code == drive_code_pkg::CODE_BANK_SELECT);
    assign wr_mode = wr_ok & (eff_code == drive_code_pkg::CODE_OP_MODE);
    assign wr_aif = wr_ok & (eff_code == drive_code_pkg::CODE_AUTOMATION_EN);
    assign wr_defaults = wr_ok & (eff_code == drive_code_pkg::CODE_LOAD_DEFAULTS);
    assign wr_clear = wr_ok & (eff_code == drive_code_pkg::CODE_FAULT_FLAG);
    // Acknowledge only counts once the source has gone
    assign clear_done = wr_clear & trip_reg & ~I_TRIP_SRC;

    // ********************************************************
    // Setting registers
    // ********************************************************
    always_ff @(posedge I_CLK) begin
        if (!I_NRST || wr_defaults) begin
            node_reg <= drive_code_pkg::NODE_RESET;
            baud_reg <= drive_code_pkg::BAUD_RESET;
            bank_reg <= drive_code_pkg::BANK_RESET;
            mode_reg <= drive_code_pkg::MODE_RESET;
        end else begin
            if (wr_node) node_reg <= wd[6:0];
            if (wr_baud) baud_reg <= wd[1:0];
            if (wr_bank) bank_reg <= wd[2:0];
            if (wr_mode) mode_reg <= wd[2:0];
        end
    end

    // Enable survives a default load, reset or a write of 0 clears it
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            aif_reg <= drive_code_pkg::AUTOMATION_RESET;
        end else if (wr_aif) begin
            aif_reg <= wd[0];
        end
    end

    // ********************************************************
    // Trip latch, a live source beats any clear
    // ********************************************************
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            trip_reg <= 1'b0;
            trip_code_reg <= 8'h00;
        end else if (I_TRIP_SRC) begin
            trip_reg <= 1'b1;
            if (!trip_reg) trip_code_reg <= I_TRIP_CODE;
        end else if (clear_done) begin
            trip_reg <= 1'b0;
        end
    end

    // History records each trip as it is reset
    trip_history u_trip_history (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_push(clear_done),
        .i_trip_code(trip_code_reg),
        .o_entries(hist_entries)
    );

    // ********************************************************
    // Communication error number and change flag
    // ********************************************************
    logic rd_byte;
    assign rd_byte = req_ok & I_CODE_RD & (eff_code == drive_code_pkg::CODE_STATE_BYTE);

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            comm_err_reg <= drive_code_pkg::COMM_ERR_NONE;
        end else if (req_any & I_FRAME_ERR) begin
            comm_err_reg <= drive_code_pkg::COMM_ERR_FRAME;
        end else if (req_ok & ~code_known) begin
            comm_err_reg <= drive_code_pkg::COMM_ERR_CODE;
        end else if (wr_bad) begin
            comm_err_reg <= drive_code_pkg::COMM_ERR_RANGE;
        end else if (req_ok) begin
            comm_err_reg <= drive_code_pkg::COMM_ERR_NONE;
        end
    end

    // Set wins over the clear by a byte read
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            parameter_change_flag_reg <= 1'b0;
        end else if (wr_ok) begin
            parameter_change_flag_reg <= 1'b1;
        end else if (rd_byte) begin
            parameter_change_flag_reg <= 1'b0;
        end
    end

    // ********************************************************
    // Telegram answer, individual address only
    // ********************************************************
    logic answer;
    assign answer = (I_CODE_WR | I_CODE_RD) & addr_own;

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            ack_reg <= 1'b0;
            nak_reg <= 1'b0;
        end else begin
            // Broadcast telegrams get no answer
            ack_reg <= answer & req_ok & code_known & ~wr_bad;
            nak_reg <= answer & ~(req_ok & code_known & ~wr_bad);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            rdata_reg <= 16'h0000;
        end else if (answer & req_ok & I_CODE_RD) begin
            rdata_reg <= code_value(eff_code);
        end
    end

    // ********************************************************
    // Local display, serial-only codes hidden
    // ********************************************************
    logic disp_hidden;
    assign disp_hidden = (I_DISP_CODE == drive_code_pkg::CODE_FAULT_FLAG)
        || (I_DISP_CODE == drive_code_pkg::CODE_STATE_WORD)
        || (I_DISP_CODE == drive_code_pkg::CODE_STATE_BYTE);

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            disp_valid_reg <= 1'b0;
            disp_data_reg <= 16'h0000;
        end else begin
            disp_valid_reg <= ~disp_hidden;
            disp_data_reg <= disp_hidden ? 16'h0000 : code_value(I_DISP_CODE);
        end
    end

    // ********************************************************
    // Baud divider lookup
    // ********************************************************
    logic [16:0] bit_cycles;
    always_comb begin
        case (baud_reg)
            2'h0: bit_cycles = 17'(drive_code_pkg::CLK_HZ / drive_code_pkg::BAUD_0_HZ);
            2'h1: bit_cycles = 17'(drive_code_pkg::CLK_HZ / drive_code_pkg::BAUD_1_HZ);
            2'h2: bit_cycles = 17'(drive_code_pkg::CLK_HZ / drive_code_pkg::BAUD_2_HZ);
            default: bit_cycles = 17'(drive_code_pkg::CLK_HZ / drive_code_pkg::BAUD_3_HZ);
        endcase
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign O_CODE_ACK = ack_reg;
    assign O_CODE_NAK = nak_reg;
    assign O_CODE_RDATA = rdata_reg;
    assign O_DISP_VALID = disp_valid_reg;
    assign O_DISP_DATA = disp_data_reg;
    assign O_NODE_ADDR = node_reg;
    assign O_BAUD_SEL = baud_reg;
    assign O_BIT_CYCLES = bit_cycles;
    assign O_OP_MODE = mode_reg;
    assign O_AUTOMATION_EN = aif_reg;
    assign O_PULSE_INHIBIT = pulse_inhibit;
    // Ready does not depend on a fitted module
    assign O_READY = ~trip_reg;

endmodule

`default_nettype wire

// ===== hw/drive_code_pkg.sv
// Constants shared by the serial parameter code bank
package drive_code_pkg;

    // ********************************************************
    // Clock and serial rates
    // ********************************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_0_HZ = 9600;
    localparam int BAUD_1_HZ = 4800;
    localparam int BAUD_2_HZ = 2400;
    localparam int BAUD_3_HZ = 1200;

    // ********************************************************
    // Code numbers (effective, after bank offset)
    // ********************************************************
    localparam logic [10:0] CODE_OP_MODE = 11'h001;
    localparam logic [10:0] CODE_LOAD_DEFAULTS = 11'h002;
    localparam logic [10:0] CODE_NODE_ADDRESS = 11'h009;
    localparam logic [10:0] CODE_FAULT_FLAG = 11'h02b;
    localparam logic [10:0] CODE_STATE_WORD = 11'h044;
    localparam logic [10:0] CODE_STATE_BYTE = 11'h045;
    localparam logic [10:0] CODE_BAUD_SELECT = 11'h07d;
    localparam logic [10:0] CODE_HIST_NEWEST = 11'h0a1;
    localparam logic [10:0] CODE_HIST_OLDEST = 11'h0a8;
    localparam logic [10:0] CODE_BANK_SELECT = 11'h0f9;
    localparam logic [10:0] CODE_AUTOMATION_EN = 11'h172;
    localparam logic [10:0] CODE_LAST = 11'h7d0;
    localparam logic [10:0] BANK_STEP = 11'h0fa;

    // ********************************************************
    // Value limits and reset values
    // ********************************************************
    localparam logic [15:0] NODE_MIN = 16'h0001;
    localparam logic [15:0] NODE_MAX = 16'h0063;
    localparam logic [15:0] BAUD_MAX = 16'h0003;
    localparam logic [15:0] BANK_MAX = 16'h0007;
    localparam logic [15:0] MODE_MAX = 16'h0007;
    localparam logic [15:0] ENABLE_MAX = 16'h0001;
    localparam logic [6:0] NODE_RESET = 7'h01;
    localparam logic [1:0] BAUD_RESET = 2'h0;
    localparam logic [2:0] BANK_RESET = 3'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic AUTOMATION_RESET = 1'b0;
    localparam int HIST_DEPTH = 8;

    // ********************************************************
    // Communication error numbers
    // ********************************************************
    localparam logic [3:0] COMM_ERR_NONE = 4'h0;
    localparam logic [3:0] COMM_ERR_FRAME = 4'h1;
    localparam logic [3:0] COMM_ERR_RANGE = 4'h2;
    localparam logic [3:0] COMM_ERR_CODE = 4'h3;

    // ********************************************************
    // Status word and byte bit positions
    // ********************************************************
    localparam int SW_TRIP = 15;
    localparam int SW_CUR_LIMIT = 13;
    localparam int SW_QUICK_STOP = 12;
    localparam int SW_PULSE_INHIBIT = 11;
    localparam int SW_RUN = 10;
    localparam int SW_ZERO_SPEED = 9;
    localparam int SW_CTRL_ENABLE = 8;
    localparam int SW_COMM_ERR_LSB = 4;
    localparam int SW_OP_ERR_LSB = 0;
    localparam int SB_CTRL_ENABLE = 7;
    localparam int SB_CTRL_RESET = 5;
    localparam int SB_TERMINAL = 4;
    localparam int SB_SERIAL = 3;
    localparam int SB_PARAM_CHANGE = 2;
    localparam int SB_COMM_ALARM = 1;
    localparam int SB_OP_ALARM = 0;

endpackage

// ===== hw/trip_history.sv
// Eight-entry trip history, newest entry first
`timescale 1ns/100ps
`default_nettype none

module trip_history (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Push of a freshly reset trip
    input wire logic i_push,
    input wire logic [7:0] i_trip_code,
    // All entries, entry 0 newest
    output logic [63:0] o_entries
);

    // ********************************************************
    // Storage
    // ********************************************************
    logic [7:0] hist_reg [drive_code_pkg::HIST_DEPTH];  // Entry 0 is newest

    // ********************************************************
    // Shift chain, oldest entry drops off the end
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            hist_reg[0] <= 8'h00;
        end else if (i_push) begin
            hist_reg[0] <= i_trip_code;
        end
    end

    genvar g;
    generate
        for (g = 1; g < drive_code_pkg::HIST_DEPTH; g = g + 1) begin : g_shift
            // Each entry ages one place per push
            always_ff @(posedge i_clk) begin
                if (!i_nrst) begin
                    hist_reg[g] <= 8'h00;
                end else if (i_push) begin
                    hist_reg[g] <= hist_reg[g-1];
                end
            end
            assign o_entries[g*8 +: 8] = hist_reg[g];
        end
    endgenerate

    assign o_entries[7:0] = hist_reg[0];

endmodule

`default_nettype wire

// ===== tb/code_map_monitor.sv
// Port checker for the serial parameter code bank
`timescale 1ns/100ps
`default_nettype none
module code_map_monitor (
    input wire logic I_CLK, I_NRST, I_CODE_WR, I_CODE_RD, I_FRAME_ERR, I_TRIP_SRC,
    input wire logic I_CTRL_ENABLE, O_CODE_ACK, O_CODE_NAK, O_PULSE_INHIBIT, O_READY,
    input wire logic [6:0] I_FRAME_ADDR, O_NODE_ADDR,
    input wire logic [1:0] O_BAUD_SEL,
    input wire logic [16:0] O_BIT_CYCLES
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    // Any telegram, and one aimed at this node
    sequence s_req;
        I_CODE_WR || I_CODE_RD;
    endsequence
    sequence s_own;
        s_req ##0 I_FRAME_ADDR == O_NODE_ADDR;
    endsequence
    chk_bad_frame: assert property (s_own ##0 I_FRAME_ERR |=> O_CODE_NAK && !O_CODE_ACK)
        else $error("bad frame answered");
    chk_idle_quiet: assert property (!I_CODE_WR && !I_CODE_RD |=> !O_CODE_ACK && !O_CODE_NAK)
        else $error("answer without telegram");
    chk_other_quiet: assert property (s_req ##0 I_FRAME_ADDR != O_NODE_ADDR |=>
        !O_CODE_ACK && !O_CODE_NAK) else $error("answer to other node");
    chk_node_legal: assert property (O_NODE_ADDR inside {[1:99]} && O_NODE_ADDR % 10 != 0)
        else $error("node address out of range");
    chk_bit_time: assert property (
        O_BIT_CYCLES == 17'(drive_code_pkg::CLK_HZ / (9600 >> O_BAUD_SEL))) else $error("bit time");
    chk_inhibit_mix: assert property (O_PULSE_INHIBIT == (!O_READY || !I_CTRL_ENABLE))
        else $error("pulse inhibit wrong");
    chk_trip_latch: assert property (I_TRIP_SRC |=> !O_READY)
        else $error("trip not latched");
    chk_keep_setting: assert property (!I_CODE_WR |=> $stable(O_BAUD_SEL) && $stable(O_NODE_ADDR))
        else $error("setting moved without write");
endmodule
bind serial_parameter_code_map code_map_monitor i_mon (.*);
`default_nettype wire

// ===== tb/host_model.sv
// Host side of the serial code port
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic wr, rd, ferr,
    output logic [6:0] addr,
    output logic [7:0] num,
    output logic [15:0] wdata
);
    initial {wr, rd, ferr, addr, num, wdata} = '0;
    // One telegram: strobe for one cycle, answer settled a cycle later
    task automatic xfer(logic w, logic e, logic [6:0] a, logic [7:0] n, logic [15:0] d);
        @(negedge clk);
        {wr, rd, ferr, addr, num, wdata} = {w, !w, e, a, n, d};
        @(negedge clk);
        {wr, rd} = 2'b00;
        {num, wdata} = ~{num, wdata}; // Released lines do not keep old value
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the parameter code bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 0, nrst = 0, tsrc = 0, wr, rd, ferr, ack, nak, dval, inh, rdy, aen;
    logic [7:0] tcode = '0, st = '0, num;
    logic [3:0] operr = '0;
    logic [10:0] disp = '0;
    logic [6:0] addr, node, m_node = 7'h01, v;
    logic [15:0] wdata, rdata, ddata;
    logic [16:0] bitc;
    logic [1:0] baud;
    logic [2:0] mode;
    int error_cnt = 0, compares = 0, cyc = 0;
    int unsigned seed = 41455;
    logic [7:0] hist[$];
    always #4 clk = ~clk;
    serial_parameter_code_map i_dut (.I_CLK(clk), .I_NRST(nrst), .I_CODE_WR(wr), .I_CODE_RD(rd),
        .I_FRAME_ADDR(addr), .I_FRAME_ERR(ferr), .I_CODE_NUM(num), .I_CODE_WDATA(wdata),
        .O_CODE_ACK(ack), .O_CODE_NAK(nak), .O_CODE_RDATA(rdata), .I_DISP_CODE(disp),
        .O_DISP_VALID(dval), .O_DISP_DATA(ddata), .I_TRIP_SRC(tsrc), .I_TRIP_CODE(tcode),
        .I_CUR_LIMIT(st[0]), .I_QUICK_STOP(st[1]), .I_RUN(st[2]), .I_ZERO_SPEED(st[3]),
        .I_CTRL_ENABLE(st[4]), .I_CTRL_RESET(st[5]), .I_TERMINAL_CTRL(st[6]),
        .I_SERIAL_CTRL(st[7]), .I_OP_ERR_NUM(operr), .O_NODE_ADDR(node), .O_BAUD_SEL(baud),
        .O_BIT_CYCLES(bitc), .O_OP_MODE(mode), .O_AUTOMATION_EN(aen), .O_PULSE_INHIBIT(inh),
        .O_READY(rdy));
    host_model i_host (.clk(clk), .wr(wr), .rd(rd), .ferr(ferr), .addr(addr), .num(num),
        .wdata(wdata));
    // Pseudo-random source
    function automatic int unsigned xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(string n, logic [16:0] s, logic [16:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // Telegram with expected answer: 2 = ack, 1 = nak, 0 = silent
    task automatic go(logic w, logic [6:0] a, logic [7:0] n, logic [15:0] d, logic [1:0] e);
        i_host.xfer(w, 1'b0, a, n, d);
        chk("answer", {ack, nak}, e);
    endtask
    task automatic conclude();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1;
        for (int b = 0; b < 5; b++) begin
            go(1, m_node, 8'h7d, 16'(b), b < 4 ? 2'd2 : 2'd1);
            chk("cycles", bitc, 17'(125000000 / (9600 >> (b < 4 ? b : 3))));
        end
        $display("test baud done");
        for (int i = 0; i < 9; i++) begin
            v = i < 2 ? 7'(30 + 70 * i) : (i == 8 ? 7'd57 : 7'(xs()));
            go(1, m_node, 8'h09, 16'(v), (v > 0 && v < 100 && v % 10 != 0) ? 2'd2 : 2'd1);
            if (v > 0 && v < 100 && v % 10 != 0) m_node = v;
            chk("node", 16'(node), 16'(m_node));
        end
        go(1, 7'd50, 8'h7d, 16'h2, 2'd0);
        chk("group", 16'(baud), 16'h2);
        i_host.xfer(0, 1, m_node, 8'h44, 0);
        chk("frame", {ack, nak}, 2'h1);
        for (int m = 4; m < 9; m++) go(1, m_node, 8'h01, 16'(m), m < 8 ? 2'd2 : 2'd1);
        chk("mode", 16'(mode), 16'h7);
        $display("test node done");
        repeat (9) begin
            tcode = 8'(xs());
            tsrc = 1;
            go(1, m_node, 8'h2b, 16'h0, 2'd2);
            go(0, m_node, 8'h2b, 16'h0, 2'd2);
            chk("fault", rdata, 16'h1);
            tsrc = 0;
            go(1, m_node, 8'h2b, 16'h0, 2'd2);
            hist.push_front(tcode);
        end
        go(0, m_node, 8'h2b, 16'h0, 2'd2);
        chk("fault", rdata, 16'h0);
        for (int i = 0; i < 8; i++) begin
            go(0, m_node, 8'(8'ha1 + i), 16'h0, 2'd2);
            chk("hist", rdata, {8'h0, hist[i]});
        end
        $display("test trip done");
        {st, operr} = 12'(xs());
        go(1, m_node, 8'h7d, 16'h0, 2'd2);
        go(0, m_node, 8'h44, 16'h0, 2'd2);
        chk("word", rdata, {2'b0, st[0], st[1], !st[4], st[2], st[3], st[4], 4'h0, operr});
        go(0, m_node, 8'h45, 16'h0, 2'd2);
        chk("byte", rdata, {8'h0, st[4], 1'b0, st[5], st[6], st[7], 2'b10, |operr});
        disp = 11'h02b;
        repeat (2) @(negedge clk);
        chk("hidden", {dval, ddata}, 17'h0);
        go(1, m_node, 8'hf9, 16'h1, 2'd2);
        go(1, m_node, 8'h78, 16'h2, 2'd1);
        go(1, m_node, 8'h78, 16'h1, 2'd2);
        chk("enable", {aen, rdy}, 2'b11);
        go(0, m_node, 8'hff, 16'h0, 2'd1);
        $display("test bank done");
        conclude();
    end
endmodule
`default_nettype wire
